/* File: addr_branch_core.sv */
// Operand addressing, branch control and execution sequencer of the 8-bit core
//
// Operation
// - Immediate operand byte is fetched from the address right after the opcode.
// - Short load of pointer B: 4-bit value low, upper nibble cleared.
// - Table load reads {upper pc byte, acc} into acc; pc keeps its value.
// - Program counter is two bytes; upper top bit unused, 15-bit address.
// - Relative jump: six-bit field, distance -31 to +32 from opcode.
// - Absolute jump replaces low 12 pc bits, upper three unchanged.
// - Long absolute jump loads all 15 pc bits from the instruction.
// - Indirect jump reads {upper pc byte, acc} into the lower pc byte.
// - Vector select loads a two-byte vector from adjacent program addresses.
// - A skipped instruction is stepped over and executed as a no-op.
// - Conditionals run the next instruction if true, skip it if false.
// - Calls push pc on the stack before jumping; returns pop it back.
// - Add, subtract, with or without carry, inc, dec, decimal fix, clear, carry ops.
// - AND, OR and exclusive-OR on the accumulator.
// - Rotate accumulator through carry both ways; swap its nibbles.
// - Set or clear any memory bit; one instruction clears soft pending flag.
// - Loads take their source from the selected addressing mode; exchange always uses pointer B.
// - Pointer post-increment or decrement happens after the memory access.
// - Push writes at stack pointer then decrements; pop increments then reads.
`timescale 1ns/1ps
`default_nettype none
module addr_branch_core
  import core_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Program memory, read data valid one cycle after the request
  output var core_pkg::prog_req_type prog_req,
  input wire logic [7:0] prog_data,
  // Data memory, read data valid one cycle after the request
  output var core_pkg::data_req_type data_req,
  input wire logic [7:0] data_rdata,
  // Interrupt side
  input wire logic [14:0] vector_addr,
  input wire logic soft_int_set,
  output logic soft_int_pending,
  // Architectural state view
  output var core_pkg::core_view_type view
);
  import core_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_sync_q;
  core_state_type s_q;
  core_state_type s_d;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    logic [1:0] len;
    len = 2'd1;
    if (op[7:4] == GRP_JMP || op[7:4] == GRP_CALL) len = 2'd2;
    if (op[7:6] == CLS_ALU && (op[2:0] == SRC_IMM || op[2:0] == SRC_DIR)) len = 2'd2;
    if (op == OP_IFEQ || op == OP_IFNE || op == OP_IFGT) len = 2'd2;
    if (op == OP_LONG_ABSOLUTE_JUMP) len = 2'd3;
    return len;
  endfunction

  // Returns {carry, half carry, result}
  function automatic logic [9:0] alu_op(input logic [2:0] f, input logic [7:0] a,
                                        input logic [7:0] m, input logic c);
    logic [7:0] b;
    logic cin;
    logic [8:0] s;
    logic [4:0] h;
    b = (f == F_SUB || f == F_SUBC) ? ~m : m;
    cin = (f == F_SUB) ? 1'b1 : ((f == F_ADC || f == F_SUBC) ? c : 1'b0);
    s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    case (f)
      F_AND: s[7:0] = a & m;
      F_OR: s[7:0] = a | m;
      F_XOR: s[7:0] = a ^ m;
      F_LD: s[7:0] = m;
      default: s[7:0] = s[7:0];
    endcase
    return {s[8], h[4], s[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic go;
    logic [7:0] mval;
    logic [9:0] r;
    logic [1:0] len;
    logic [2:0] src;
    logic use_x;
    go = 1'b0;
    mval = 8'h00;
    r = 10'h000;
    len = 2'd1;
    src = s_q.opcode[2:0];
    use_x = (src == SRC_X) || (src == SRC_XINC) || (src == SRC_XDEC);
    s_d = s_q;
    s_d.prog.rd = 1'b0;
    s_d.data.rd = 1'b0;
    s_d.data.wr = 1'b0;
    case (s_q.st)
      ST_FETCH: begin
        s_d.prog.rd = 1'b1;
        s_d.prog.addr = s_q.pc;
        s_d.ret = ST_DECODE;
        s_d.st = ST_WAIT;
      end
      ST_WAIT: s_d.st = s_q.ret;
      ST_DECODE: begin
        s_d.opcode = prog_data;
        len = instr_len(prog_data);
        if (s_q.skip) begin
          // Walk over the whole skipped instruction without side effects
          s_d.skip = 1'b0;
          s_d.pc = s_q.pc + {13'h0000, len};
          s_d.st = ST_FETCH;
        end else begin
          s_d.pc = s_q.pc + 15'd1;
          s_d.opnd_left = len - 2'd1;
          s_d.opnd_idx = 1'b0;
          if (len == 2'd1) begin
            s_d.st = ST_EXEC;
          end else begin
            s_d.prog.rd = 1'b1;
            s_d.prog.addr = s_q.pc + 15'd1;
            s_d.ret = ST_OPND;
            s_d.st = ST_WAIT;
          end
        end
      end
      ST_OPND: begin
        if (!s_q.opnd_idx) s_d.opnd1 = prog_data;
        else s_d.opnd2 = prog_data;
        s_d.opnd_idx = 1'b1;
        s_d.pc = s_q.pc + 15'd1;
        s_d.opnd_left = s_q.opnd_left - 2'd1;
        if (s_q.opnd_left == 2'd1) begin
          s_d.st = ST_EXEC;
        end else begin
          s_d.prog.rd = 1'b1;
          s_d.prog.addr = s_q.pc + 15'd1;
          s_d.ret = ST_OPND;
          s_d.st = ST_WAIT;
        end
      end
      ST_EXEC: begin
        s_d.st = ST_FETCH;
        s_d.ret = ST_DCAP;
        if (s_q.opcode[7:6] == CLS_REL) begin
          // A +1 field lands on the next opcode; software uses a no-op there
          s_d.pc = s_q.pc - REL_BIAS + {9'h000, s_q.opcode[5:0]};
        end else if (s_q.opcode[7:4] == GRP_LDB) begin
          s_d.ptr_b = {LOW_CLEAR, s_q.opcode[3:0]};
        end else if (s_q.opcode[7:4] == GRP_JMP) begin
          s_d.pc[11:0] = {s_q.opcode[3:0], s_q.opnd1};
        end else if (s_q.opcode[7:4] == GRP_CALL) begin
          s_d.data.wr = 1'b1;
          s_d.data.addr = s_q.sp;
          s_d.data.wdata = s_q.pc[7:0];
          s_d.st = ST_SECOND;
        end else if (s_q.opcode[7:4] == GRP_BIT) begin
          s_d.data.rd = 1'b1;
          s_d.data.addr = s_q.ptr_b;
          s_d.st = ST_WAIT;
        end else if (s_q.opcode[7:6] == CLS_ALU) begin
          if (src == SRC_IMM) begin
            go = 1'b1;
            mval = s_q.opnd1;
          end else begin
            s_d.data.rd = 1'b1;
            s_d.data.addr = (src == SRC_DIR) ? s_q.opnd1 : (use_x ? s_q.ptr_x : s_q.ptr_b);
            s_d.st = ST_WAIT;
          end
        end else begin
          case (s_q.opcode)
            OP_CLR: s_d.acc = 8'h00;
            OP_INC: s_d.acc = s_q.acc + 8'h01;
            OP_DEC: s_d.acc = s_q.acc - 8'h01;
            OP_DECIMAL_CORRECTION: begin
              s_d.acc = s_q.acc - (s_q.half_carry ? 8'h00 : DECIMAL_CORRECTION_LO)
                                - (s_q.carry ? 8'h00 : DECIMAL_CORRECTION_HI);
            end
            OP_RRC: {s_d.acc, s_d.carry} = {s_q.carry, s_q.acc};
            OP_RLC: begin
              {s_d.carry, s_d.acc} = {s_q.acc, s_q.carry};
              s_d.half_carry = s_q.acc[0];
            end
            OP_SWAP: s_d.acc = {s_q.acc[3:0], s_q.acc[7:4]};
            OP_SC: {s_d.carry, s_d.half_carry} = 2'b11;
            OP_RC: {s_d.carry, s_d.half_carry} = 2'b00;
            OP_IFC: s_d.skip = !s_q.carry;
            OP_IFNC: s_d.skip = s_q.carry;
            OP_IFEQ: s_d.skip = !(s_q.acc == s_q.opnd1);
            OP_IFNE: s_d.skip = !(s_q.acc != s_q.opnd1);
            OP_IFGT: s_d.skip = !(s_q.acc > s_q.opnd1);
            OP_PUSH: begin
              s_d.data.wr = 1'b1;
              s_d.data.addr = s_q.sp;
              s_d.data.wdata = s_q.acc;
              s_d.sp = s_q.sp - 8'h01;
            end
            OP_POP, OP_RET, OP_RETURN_THEN_SKIP: begin
              s_d.data.rd = 1'b1;
              s_d.data.addr = s_q.sp + 8'h01;
              s_d.st = ST_WAIT;
            end
            OP_XCHB: begin
              s_d.data.rd = 1'b1;
              s_d.data.addr = s_q.ptr_b;
              s_d.st = ST_WAIT;
            end
            OP_TABLE_LOAD_ACCUMULATOR, OP_JID: begin
              s_d.prog.rd = 1'b1;
              s_d.prog.addr = {s_q.pc[14:8], s_q.acc};
              s_d.ret = ST_PCAP;
              s_d.st = ST_WAIT;
            end
            OP_VIS: begin
              s_d.prog.rd = 1'b1;
              s_d.prog.addr = vector_addr;
              s_d.ret = ST_PCAP;
              s_d.st = ST_WAIT;
            end
            OP_LONG_ABSOLUTE_JUMP: s_d.pc = {s_q.opnd1[6:0], s_q.opnd2};
            OP_CLEAR_SOFT_INTERRUPT_PENDING: s_d.soft_pend = 1'b0;
            default: s_d.st = ST_FETCH;
          endcase
        end
      end
      ST_DCAP: begin
        s_d.st = ST_FETCH;
        if (s_q.opcode[7:6] == CLS_ALU) begin
          go = 1'b1;
          mval = data_rdata;
          // Pointer moves only after the access has used its old value
          case (src)
            SRC_BINC: s_d.ptr_b = s_q.ptr_b + 8'h01;
            SRC_BDEC: s_d.ptr_b = s_q.ptr_b - 8'h01;
            SRC_XINC: s_d.ptr_x = s_q.ptr_x + 8'h01;
            SRC_XDEC: s_d.ptr_x = s_q.ptr_x - 8'h01;
            default: s_d.ptr_b = s_q.ptr_b;
          endcase
        end else if (s_q.opcode[7:4] == GRP_BIT) begin
          s_d.data.wr = 1'b1;
          s_d.data.addr = s_q.ptr_b;
          s_d.data.wdata = s_q.opcode[3] ? (data_rdata & ~(BIT_ONE << s_q.opcode[2:0]))
                                         : (data_rdata | (BIT_ONE << s_q.opcode[2:0]));
        end else if (s_q.opcode == OP_POP) begin
          s_d.acc = data_rdata;
          s_d.sp = s_q.sp + 8'h01;
        end else if (s_q.opcode == OP_XCHB) begin
          s_d.acc = data_rdata;
          s_d.data.wr = 1'b1;
          s_d.data.addr = s_q.ptr_b;
          s_d.data.wdata = s_q.acc;
        end else begin
          s_d.tmp = data_rdata;
          s_d.data.rd = 1'b1;
          s_d.data.addr = s_q.sp + 8'h02;
          s_d.ret = ST_SECOND;
          s_d.st = ST_WAIT;
        end
      end
      ST_PCAP: begin
        s_d.st = ST_FETCH;
        if (s_q.opcode == OP_TABLE_LOAD_ACCUMULATOR) begin
          s_d.acc = prog_data;
        end else if (s_q.opcode == OP_JID) begin
          s_d.pc[7:0] = prog_data;
        end else begin
          s_d.tmp = prog_data;
          s_d.prog.rd = 1'b1;
          s_d.prog.addr = vector_addr + 15'd1;
          s_d.ret = ST_SECOND;
          s_d.st = ST_WAIT;
        end
      end
      ST_SECOND: begin
        s_d.st = ST_FETCH;
        if (s_q.opcode[7:4] == GRP_CALL) begin
          s_d.data.wr = 1'b1;
          s_d.data.addr = s_q.sp - 8'h01;
          s_d.data.wdata = {1'b0, s_q.pc[14:8]};
          s_d.sp = s_q.sp - 8'h02;
          s_d.pc[11:0] = {s_q.opcode[3:0], s_q.opnd1};
        end else if (s_q.opcode == OP_VIS) begin
          s_d.pc = {s_q.tmp[6:0], prog_data};
        end else begin
          s_d.pc = {s_q.tmp[6:0], data_rdata};
          s_d.sp = s_q.sp + 8'h02;
          s_d.skip = (s_q.opcode == OP_RETURN_THEN_SKIP);
        end
      end
      default: s_d.st = ST_FETCH;
    endcase
    if (go) begin
      r = alu_op(s_q.opcode[5:3], s_q.acc, mval, s_q.carry);
      s_d.acc = r[7:0];
      if (s_q.opcode[5:3] inside {F_ADC, F_SUB, F_SUBC}) begin
        s_d.carry = r[9];
        s_d.half_carry = r[8];
      end
    end
    // A new request in the clearing cycle stays pending
    if (soft_int_set) s_d.soft_pend = 1'b1;
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.ret <= ST_FETCH;
      s_q.pc <= PC_RST;
      s_q.sp <= SP_RST;
      s_q.acc <= ACC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prog_req = s_q.prog;
  assign data_req = s_q.data;
  assign soft_int_pending = s_q.soft_pend;
  assign view = '{pc_upper_byte: {1'b0, s_q.pc[14:8]}, pc_lower_byte: s_q.pc[7:0],
                  acc: s_q.acc, stack_pointer: s_q.sp, carry: s_q.carry,
                  half_carry: s_q.half_carry};

  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] jmp_field;
  logic [5:0] rel_field;
  logic in_exec;
  assign jmp_field = {s_q.opcode[3:0], s_q.opnd1};
  assign rel_field = s_q.opcode[5:0];
  assign in_exec = (s_q.st == ST_EXEC);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_q);

  property p_imm_next;
    s_q.st == ST_DECODE && !s_q.skip && instr_len(prog_data) != 2'd1
      |=> prog_req.rd && prog_req.addr == $past(s_q.pc) + 15'd1;
  endproperty
  a_imm_next: assert property (p_imm_next) else $error("operand not after opcode");

  property p_ldb;
    in_exec && s_q.opcode[7:4] == GRP_LDB |=> s_q.ptr_b[7:4] == 4'h0 && s_q.ptr_b[3:0] == $past(jmp_field[11:8]);
  endproperty
  a_ldb: assert property (p_ldb) else $error("short load of B wrong");

  property p_table_load_accumulator;
    in_exec && s_q.opcode == OP_TABLE_LOAD_ACCUMULATOR
      |=> prog_req.rd && prog_req.addr == {$past(s_q.pc[14:8]), $past(s_q.acc)}
      ##2 s_q.acc == $past(prog_data) && s_q.pc == $past(s_q.pc, 3);
  endproperty
  a_table_load_accumulator: assert property (p_table_load_accumulator) else $error("table load wrong");

  property p_rel;
    in_exec && s_q.opcode[7:6] == CLS_REL |=> s_q.pc == $past(s_q.pc) - 15'd32 + {9'h000, $past(rel_field)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative jump target wrong");

  property p_jmp;
    in_exec && s_q.opcode[7:4] == GRP_JMP
      |=> s_q.pc[14:12] == $past(s_q.pc[14:12]) && s_q.pc[11:0] == $past(jmp_field);
  endproperty
  a_jmp: assert property (p_jmp) else $error("absolute jump wrong");

  property p_skip;
    s_q.st == ST_DECODE && s_q.skip
      |=> s_q.st == ST_FETCH && !s_q.skip && !data_req.wr && s_q.acc == $past(s_q.acc);
  endproperty
  a_skip: assert property (p_skip) else $error("skipped instruction had effect");

  property p_call;
    in_exec && s_q.opcode[7:4] == GRP_CALL
      |=> data_req.wr && data_req.addr == $past(s_q.sp) && data_req.wdata == $past(s_q.pc[7:0])
      ##1 data_req.wr && data_req.addr == $past(s_q.sp, 2) - 8'h01 && s_q.pc[11:0] == $past(jmp_field, 2);
  endproperty
  a_call: assert property (p_call) else $error("call stacking wrong");

  property p_push;
    in_exec && s_q.opcode == OP_PUSH
      |=> data_req.wr && data_req.wdata == $past(s_q.acc) && s_q.sp == $past(s_q.sp) - 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_pend;
    soft_int_set |=> soft_int_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("pending request lost");

  c_skip: cover property (s_q.st == ST_DECODE && s_q.skip);
  c_call: cover property (in_exec && s_q.opcode[7:4] == GRP_CALL);
  c_vis: cover property (s_q.st == ST_SECOND && s_q.opcode == OP_VIS);
  c_ret: cover property (s_q.st == ST_SECOND && s_q.opcode == OP_RETURN_THEN_SKIP);
endmodule
`default_nettype wire

/* File: core_pkg.sv */
// Opcodes, reset values and state carriers of the 8-bit core sequencer
package core_pkg;
  localparam logic [14:0] PC_RST = 15'h0000;
  localparam logic [7:0] SP_RST = 8'h6f;
  localparam logic [7:0] ACC_RST = 8'h00;
  // Field 0 means -31, measured from the opcode address (pc-1)
  localparam logic [14:0] REL_BIAS = 15'h0020;
  localparam logic [7:0] DECIMAL_CORRECTION_LO = 8'h06;
  localparam logic [7:0] DECIMAL_CORRECTION_HI = 8'h60;
  localparam logic [3:0] LOW_CLEAR = 4'h0;
  localparam logic [7:0] BIT_ONE = 8'h01;
  // Opcode classes and groups
  localparam logic [1:0] CLS_REL = 2'h0;
  localparam logic [1:0] CLS_ALU = 2'h2;
  localparam logic [3:0] GRP_LDB = 4'h4;
  localparam logic [3:0] GRP_JMP = 4'h5;
  localparam logic [3:0] GRP_CALL = 4'h6;
  localparam logic [3:0] GRP_BIT = 4'h7;
  // ALU functions, opcode bits 5:3
  localparam logic [2:0] F_ADD = 3'h0;
  localparam logic [2:0] F_ADC = 3'h1;
  localparam logic [2:0] F_SUB = 3'h2;
  localparam logic [2:0] F_SUBC = 3'h3;
  localparam logic [2:0] F_AND = 3'h4;
  localparam logic [2:0] F_OR = 3'h5;
  localparam logic [2:0] F_XOR = 3'h6;
  localparam logic [2:0] F_LD = 3'h7;
  // ALU operand sources, opcode bits 2:0
  localparam logic [2:0] SRC_IMM = 3'h0;
  localparam logic [2:0] SRC_DIR = 3'h1;
  localparam logic [2:0] SRC_X = 3'h3;
  localparam logic [2:0] SRC_BINC = 3'h4;
  localparam logic [2:0] SRC_BDEC = 3'h5;
  localparam logic [2:0] SRC_XINC = 3'h6;
  localparam logic [2:0] SRC_XDEC = 3'h7;
  // Single-opcode instructions
  localparam logic [7:0] OP_CLR = 8'hc0;
  localparam logic [7:0] OP_INC = 8'hc1;
  localparam logic [7:0] OP_DEC = 8'hc2;
  localparam logic [7:0] OP_DECIMAL_CORRECTION = 8'hc3;
  localparam logic [7:0] OP_RRC = 8'hc4;
  localparam logic [7:0] OP_RLC = 8'hc5;
  localparam logic [7:0] OP_SWAP = 8'hc6;
  localparam logic [7:0] OP_SC = 8'hc7;
  localparam logic [7:0] OP_RC = 8'hc8;
  localparam logic [7:0] OP_IFC = 8'hc9;
  localparam logic [7:0] OP_IFNC = 8'hca;
  localparam logic [7:0] OP_PUSH = 8'hcb;
  localparam logic [7:0] OP_POP = 8'hcc;
  localparam logic [7:0] OP_TABLE_LOAD_ACCUMULATOR = 8'hcd;
  localparam logic [7:0] OP_JID = 8'hce;
  localparam logic [7:0] OP_VIS = 8'hcf;
  localparam logic [7:0] OP_RET = 8'hd0;
  localparam logic [7:0] OP_RETURN_THEN_SKIP = 8'hd1;
  localparam logic [7:0] OP_LONG_ABSOLUTE_JUMP = 8'hd2;
  localparam logic [7:0] OP_CLEAR_SOFT_INTERRUPT_PENDING = 8'hd3;
  localparam logic [7:0] OP_XCHB = 8'hd4;
  localparam logic [7:0] OP_IFEQ = 8'hd5;
  localparam logic [7:0] OP_IFNE = 8'hd6;
  localparam logic [7:0] OP_IFGT = 8'hd7;
  localparam logic [7:0] OP_NOP = 8'hd8;

  typedef enum logic [2:0] {
    ST_FETCH, ST_WAIT, ST_DECODE, ST_OPND, ST_EXEC, ST_DCAP, ST_PCAP, ST_SECOND
  } core_st_type;

  typedef struct packed {
    logic rd;
    logic [14:0] addr;
  } prog_req_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } data_req_type;

  typedef struct packed {
    logic [7:0] pc_upper_byte;
    logic [7:0] pc_lower_byte;
    logic [7:0] acc;
    logic [7:0] stack_pointer;
    logic carry;
    logic half_carry;
  } core_view_type;

  typedef struct packed {
    core_st_type st;
    core_st_type ret;
    logic [14:0] pc;
    logic [7:0] acc;
    logic [7:0] ptr_b;
    logic [7:0] ptr_x;
    logic [7:0] sp;
    logic carry;
    logic half_carry;
    logic skip;
    logic soft_pend;
    logic [7:0] opcode;
    logic [7:0] opnd1;
    logic [7:0] opnd2;
    logic [7:0] tmp;
    logic [1:0] opnd_left;
    logic opnd_idx;
    prog_req_type prog;
    data_req_type data;
  } core_state_type;
endpackage

/* File: prog_data_memory_model.sv */
// Program and data memory model that answers the core sequencer
`timescale 1ns/1ps
`default_nettype none
module prog_data_memory_model
  import core_pkg::*;
(
  // Clock
  input wire logic clk,
  // Program side
  input wire core_pkg::prog_req_type prog_req,
  output logic [7:0] prog_data,
  // Data side
  input wire core_pkg::data_req_type data_req,
  output logic [7:0] data_rdata
);
  logic [7:0] pm [0:32767];
  logic [7:0] dm [0:255];

  initial begin
    foreach (pm[i]) pm[i] = 8'hc0;
    foreach (dm[i]) dm[i] = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lines toggle outside the answer cycle, so a sample one cycle late sees the inverted data
  always @(posedge clk) begin
    prog_data <= prog_req.rd ? pm[prog_req.addr] : ~prog_data;
    data_rdata <= data_req.rd ? dm[data_req.addr] : ~data_rdata;
    if (data_req.wr) begin
      dm[data_req.addr] <= data_req.wdata;
    end
  end
endmodule
`default_nettype wire

/* File: cpu_addressing_and_branch_control_tb.sv */
// Self-checking testbench of the addressing and branch sequencer
`timescale 1ns/1ps
`default_nettype none
module cpu_addressing_and_branch_control_tb;
  import core_pkg::*;
  logic clk, rst_b, soft_int_set, soft_int_pending;
  logic [14:0] vector_addr, pa, ra;
  prog_req_type prog_req;
  data_req_type data_req;
  core_view_type view;
  logic [7:0] prog_data, data_rdata, a, sp, r;
  logic [8:0] w;
  logic h;
  logic [15:0] q [$];
  int error_cnt, checks_done, cyc;

  addr_branch_core dut (.clk(clk), .rst_b(rst_b), .prog_req(prog_req), .prog_data(prog_data),
    .data_req(data_req), .data_rdata(data_rdata), .vector_addr(vector_addr),
    .soft_int_set(soft_int_set), .soft_int_pending(soft_int_pending), .view(view));
  prog_data_memory_model mem (.clk(clk), .prog_req(prog_req), .prog_data(prog_data),
    .data_req(data_req), .data_rdata(data_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task b(input logic [7:0] v);
    mem.pm[pa] = v;
    pa = pa + 15'h1;
  endtask

  task b2(input logic [7:0] o, input logic [7:0] v);
    b(o);
    b(v);
  endtask

  // Push the accumulator and note the stack write that must follow
  task pu(input logic [7:0] v);
    b(8'hcb);
    q.push_back({sp, v});
    sp = sp - 8'h1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Every data write is a result; it must match the oldest note
  always @(posedge clk) begin
    if (rst_b && data_req.wr) begin
      if (q.size() == 0) cmp({data_req.addr, data_req.wdata}, 16'hxxxx);
      else cmp({data_req.addr, data_req.wdata}, q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      tally_and_finish;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    soft_int_set = 1'b0;
    vector_addr = 15'h7400;
    pa = 15'h0000;
    sp = SP_RST;
    r = 8'($urandom(83));
    #1;
    a = 8'($urandom); b2(8'hb8, a); pu(a);
    b2(8'hb0, 8'hff); a = ~a; pu(a);
    r = 8'($urandom); b2(8'ha0, r); a = a & r; pu(a);
    r = 8'($urandom); b2(8'ha8, r); a = a | r; pu(a);
    r = 8'($urandom); b2(8'h80, r); a = a + r; pu(a);
    b(8'hc6); a = {a[3:0], a[7:4]}; pu(a);
    r = a; b(8'hc7); b(8'hc4); a = {1'b1, a[7:1]}; pu(a);
    b(8'hc5); a = {a[6:0], r[0]}; pu(a);
    b(8'hc1); b(8'hc2); b(8'hc2); a = a - 8'h1; pu(a);
    b(8'hc0); b(8'hcc); sp = sp + 8'h1; pu(a);
    b(8'h47); b(8'h73); q.push_back(16'h0708);
    b(8'h7b); q.push_back(16'h0700);
    ra = pa; b(8'h3f); pa = ra + 15'd32; pu(a);
    b2(8'h53, 8'h00); pa = 15'h0300; pu(a);
    b(8'hd2); b2(8'h71, 8'h10); pa = 15'h7110; pu(a);
    b2(8'h52, 8'h00); pa = 15'h7200;
    b2(8'hb8, 8'h40); b(8'hce); mem.pm[15'h7240] = 8'h80; pa = 15'h7280;
    a = 8'h40; pu(a);
    r = 8'($urandom); mem.pm[15'h7241] = r; b2(8'hb8, 8'h41); b(8'hcd); a = r; pu(a);
    b(8'hc8); b(8'hc9); b2(8'hb8, 8'h55); pu(a);
    b(8'hca); b2(8'hb8, 8'h66); b2(8'hd5, 8'h66); b(8'hc1);
    b2(8'hd7, 8'h99); b(8'hc1); a = 8'h67; pu(a);
    // Exchange, load with post-increment, exchange at the moved pointer, direct load back
    b(8'hd4); b(8'hbc); b(8'hd4); b2(8'hb9, 8'h07);
    q.push_back({8'h07, a}); q.push_back({8'h08, a});
    r = 8'($urandom); b(8'hc7); b2(8'h88, r); w = {1'b0, a} + {1'b0, r} + 9'h001;
    h = ({1'b0, a[3:0]} + {1'b0, r[3:0]} + 5'h01) > 5'h0f; a = w[7:0]; pu(a);
    b(8'hc3); a = a - (h ? 8'h00 : DECIMAL_CORRECTION_LO) - (w[8] ? 8'h00 : DECIMAL_CORRECTION_HI); pu(a);
    r = 8'($urandom); b2(8'h90, r); w = {1'b0, a} + {1'b0, ~r} + 9'h001;
    b(8'hc4); a = {w[8], w[7:1]}; pu(a);
    b(8'hc8); b2(8'hd6, a); b(8'hc1); pu(a);
    ra = pa + 15'h2; b2(8'h67, 8'h00);
    q.push_back({sp, ra[7:0]}); q.push_back({sp - 8'h1, 1'b0, ra[14:8]});
    mem.pm[15'h7700] = 8'hc1; mem.pm[15'h7701] = 8'hd0; a = a + 8'h1; pu(a);
    ra = pa + 15'h2; b2(8'h67, 8'h02); b(8'hc1); mem.pm[15'h7702] = 8'hd1;
    q.push_back({sp, ra[7:0]}); q.push_back({sp - 8'h1, 1'b0, ra[14:8]}); pu(a);
    mem.pm[15'h7400] = 8'h75; mem.pm[15'h7401] = 8'h00; b(8'hcf); pa = 15'h7500;
    pu(a); b(8'hd3);
    b(8'h1f);
    repeat (3) @(negedge clk);
    cmp({view.pc_upper_byte, view.pc_lower_byte}, 16'h0000);
    cmp({8'h00, view.stack_pointer}, {8'h00, SP_RST});
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    soft_int_set = 1'b1;
    @(negedge clk);
    soft_int_set = 1'b0;
    @(negedge clk);
    cmp({15'h0, soft_int_pending}, 16'h0001);
    while (q.size() != 0) @(negedge clk);
    repeat (20) @(negedge clk);
    cmp({15'h0, soft_int_pending}, 16'h0000);
    cmp({view.pc_upper_byte, view.stack_pointer}, {8'h75, sp});
    cmp({view.acc, 6'h00, view.carry, view.half_carry}, {a, 8'h00});
    tally_and_finish;
  end
endmodule
`default_nettype wire
